// ==== core/ulst_dev.sv ====
// device end: attach, packet gaps, suspend/reset, chirp handshake, speed
// assumes the host end keeps its own timing and shares i_sys_clk
`timescale 1ns/100ps
`default_nettype none
module ulst_dev import ulst_pkg::*; #(
  parameter int P_CSR_CYC = C_CSR,
  parameter int P_CHIRP_K_CYC = C_CHIRPK,
  parameter int P_HS_WIN_CYC = C_SCS
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  ulst_link_if.dev link,
  input wire logic i_power_good,
  input wire logic i_tx_req,
  input wire logic i_tx_done,
  output logic o_tx_ready,
  output logic o_tx_active,
  output logic o_link_speed_flag,
  output logic o_bus_reset_event,
  output logic o_suspend_indicator_out,
  output logic o_resume_indicator_out
);
  ulst_dev_st_t st;
  logic [31:0] cnt;
  logic [31:0] idle_cnt;
  logic [31:0] run_cnt;
  logic [31:0] gap_cnt;
  logic [1:0] line_q;
  logic [2:0] kj_cnt;
  logic want_j;
  logic hs;
  logic line_chg;
  logic sample;
  logic in_susp;
  logic tx_start;
  logic reset_end;

  assign line_chg = link.line != line_q;
  assign in_susp = (st == D_SUSP) || (st == D_WAKE);
  // host chirps are K/J inside the reset, so only a step up from SE0 ends it
  assign reset_end = (link.line != LINE_SE0) && (line_q == LINE_SE0);
  // idle window reached with line steady the whole time
  assign sample = (st == D_ACTIVE) && !line_chg && !link.host_eop &&
                  !link.dev_pkt && (idle_cnt == 32'(P_CSR_CYC - 1));

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      line_q <= LINE_SE0;
    end else begin
      line_q <= link.line;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || line_chg) begin
      run_cnt <= 32'h0;
    end else if (~&run_cnt) begin
      run_cnt <= run_cnt + 32'h1;
    end
  end

  // traffic or any line change restarts the idle window
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || line_chg || link.host_eop || link.dev_pkt) begin
      idle_cnt <= 32'h0;
    end else if (idle_cnt < 32'(P_CSR_CYC)) begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      st <= D_OFF;
      cnt <= 32'h0;
      hs <= 1'b0;
      kj_cnt <= 3'h0;
      want_j <= 1'b0;
    end else begin
      unique case (st)
        D_OFF: begin
          if (i_power_good) begin
            st <= D_ACTIVE;
          end
        end
        D_ACTIVE: begin
          if (!i_power_good) begin
            st <= D_OFF;
          end else if (sample && (link.line == LINE_SE0)) begin
            // reset seen 100 us in, well inside the start window
            st <= D_CHIRP;
            cnt <= 32'h0;
            hs <= 1'b0;
          end else if (sample && (link.line == LINE_J)) begin
            st <= D_SUSP;
          end
        end
        D_SUSP: begin
          if ((link.line == LINE_SE0) && (run_cnt == 32'(C_SCA - 1))) begin
            st <= D_CHIRP;
            cnt <= 32'h0;
            hs <= 1'b0;
          end else if (link.line == LINE_K) begin
            // speed flag is kept, so a high-speed link resumes at once
            st <= D_ACTIVE;
          end else if (link.resume_request_in) begin
            st <= D_WAKE;
          end
        end
        D_WAKE: begin
          if (!link.resume_request_in) begin
            st <= D_ACTIVE;
          end
        end
        D_CHIRP: begin
          cnt <= cnt + 32'h1;
          if (cnt == 32'(P_CHIRP_K_CYC - 1)) begin
            st <= D_HSWAIT;
            cnt <= 32'h0;
            kj_cnt <= 3'h0;
            want_j <= 1'b0;
          end
        end
        D_HSWAIT: begin
          cnt <= cnt + 32'h1;
          if ((run_cnt == 32'(C_CSI - 1)) &&
              (link.line == (want_j ? LINE_J : LINE_K))) begin
            kj_cnt <= kj_cnt + 3'h1;
            want_j <= ~want_j;
            if (kj_cnt == KJ_NEEDED - 3'h1) begin
              hs <= 1'b1;
              st <= D_RSTEND;
            end
          end else if (cnt == 32'(P_HS_WIN_CYC - 1)) begin
            st <= D_RSTEND;
          end
        end
        D_RSTEND: begin
          if (reset_end) begin
            st <= D_ACTIVE;
          end
        end
        default: begin
          st <= D_OFF;
        end
      endcase
    end
  end

  // gap counter also serves the reply window; a request held at the
  // host packet end starts exactly at the least gap, inside the most
  assign tx_start = i_tx_req && o_tx_ready;
  // a host packet end restarts the gap, so nothing may start in that cycle
  assign o_tx_ready = (st == D_ACTIVE) && !link.dev_pkt && !link.host_eop &&
                      (gap_cnt >= 32'(C_IPD - 1));

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      gap_cnt <= 32'(C_IPD);
    end else if (link.host_eop || (link.dev_pkt && i_tx_done)) begin
      gap_cnt <= 32'h0;
    end else if (gap_cnt < 32'(C_IPD)) begin
      gap_cnt <= gap_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || (st != D_ACTIVE)) begin
      link.dev_pkt <= 1'b0;
    end else if (link.dev_pkt && i_tx_done) begin
      link.dev_pkt <= 1'b0;
    end else if (tx_start) begin
      link.dev_pkt <= 1'b1;
    end
  end

  assign o_tx_active = link.dev_pkt;
  assign link.dev_attach = st != D_OFF;
  assign link.dev_drive = (st == D_CHIRP) || (st == D_WAKE);
  assign link.dev_line = link.dev_drive ? LINE_K : LINE_J;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_link_speed_flag <= 1'b0;
      o_bus_reset_event <= 1'b0;
    end else begin
      o_link_speed_flag <= hs;
      o_bus_reset_event <= (st == D_RSTEND) && reset_end;
    end
  end

  // leaving suspend by a bus reset also raises the resume pulse
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_suspend_indicator_out <= 1'b0;
      o_resume_indicator_out <= 1'b0;
    end else begin
      o_suspend_indicator_out <= in_susp;
      o_resume_indicator_out <= o_suspend_indicator_out && !in_susp;
    end
  end
endmodule // ulst_dev
`default_nettype wire

// ==== core/ulst_pkg.sv ====
// link-state timing package: line codes, states, time constants, cycle counts
// assumes a 100 MHz system clock shared by both ends of the link
package ulst_pkg;
  localparam int CLK_NS = 10;
  localparam int PS_PER_CYC = CLK_NS * 1000;
  localparam int NS_PER_US = 1000;
  localparam int NS_PER_MS = 1000000;

  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;

  // full-speed bit time in picoseconds
  localparam int FS_BIT_PS = 83333;
  localparam int T_IPD_BT = 2;
  localparam int C_IPD = (T_IPD_BT * FS_BIT_PS + PS_PER_CYC - 1) / PS_PER_CYC;
  localparam real T_RSP_BT = 6.5;
  localparam int C_RSP_MAX = $rtoi(T_RSP_BT * FS_BIT_PS) / PS_PER_CYC;

  localparam int T_CSR_US = 100;
  localparam int C_CSR = T_CSR_US * NS_PER_US / CLK_NS;
  localparam int T_SCA_NS = 2500;
  localparam int C_SCA = (T_SCA_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CSI_NS = 2500;
  localparam int C_CSI = (T_CSI_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CHIRPK_MS = 1;
  localparam int C_CHIRPK = T_CHIRPK_MS * NS_PER_MS / CLK_NS;
  localparam real T_SCS_MS = 2.5;
  localparam int C_SCS = $rtoi(T_SCS_MS * NS_PER_MS) / CLK_NS;
  localparam logic [2:0] KJ_NEEDED = 3'h6;

  localparam int T_ATTDB_MS = 100;
  localparam int C_ATTDB = T_ATTDB_MS * NS_PER_MS / CLK_NS;
  localparam int T_DRS_MS = 10;
  localparam int C_DRS = T_DRS_MS * NS_PER_MS / CLK_NS;
  localparam int T_FSC_LEAD_US = 300;
  localparam int C_FSC_LEAD = T_FSC_LEAD_US * NS_PER_US / CLK_NS;
  localparam int T_KJ_US = 40;
  localparam int C_KJ = T_KJ_US * NS_PER_US / CLK_NS;
  localparam int T_WAKE_MS = 2;
  localparam int C_WAKE = T_WAKE_MS * NS_PER_MS / CLK_NS;
  localparam int T_HRES_MS = 2;
  localparam int C_HRES = T_HRES_MS * NS_PER_MS / CLK_NS;

  typedef enum logic [2:0] {
    D_OFF, D_ACTIVE, D_SUSP, D_WAKE, D_CHIRP, D_HSWAIT, D_RSTEND
  } ulst_dev_st_t;

  typedef enum logic [2:0] {
    H_DETACH, H_DEBOUNCE, H_RESET, H_IDLE, H_RESUME
  } ulst_host_st_t;
endpackage

// ==== core/ulst_link_if.sv ====
// link carrier between device end and host end
// assumes both ends share one clock; the line level is resolved here
`timescale 1ns/100ps
`default_nettype none
interface ulst_link_if;
  import ulst_pkg::*;
  logic dev_attach;
  logic dev_drive;
  logic [1:0] dev_line;
  logic dev_pkt;
  logic host_drive;
  logic [1:0] host_line;
  logic host_eop;
  logic resume_request_in;
  logic [1:0] line;

  // host wins a collision; undriven attached line idles at J
  assign line = host_drive ? host_line :
                dev_drive ? dev_line :
                dev_attach ? LINE_J : LINE_SE0;

  modport dev (
    output dev_attach, dev_drive, dev_line, dev_pkt,
    input host_eop, resume_request_in, line
  );
  modport host (
    output host_drive, host_line, host_eop, resume_request_in,
    input dev_attach, dev_drive, dev_line, dev_pkt, line
  );
endinterface
`default_nettype wire

// ==== core/ulst_host.sv ====
// host end: debounce, bus reset with K-J chirps, resume, wake requester
// assumes the device end on the same link interface and clock
`timescale 1ns/100ps
`default_nettype none
module ulst_host import ulst_pkg::*; #(
  parameter int P_DEBOUNCE_CYC = C_ATTDB,
  parameter int P_RESET_CYC = C_DRS,
  parameter int P_FSC_LEAD_CYC = C_FSC_LEAD,
  parameter int P_KJ_CYC = C_KJ,
  parameter int P_WAKE_CYC = C_WAKE,
  parameter int P_RESUME_CYC = C_HRES
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  ulst_link_if.host link,
  input wire logic i_hs_capable,
  input wire logic i_bus_reset,
  input wire logic i_resume,
  input wire logic i_wake,
  input wire logic i_pkt_end,
  output logic o_connected,
  output logic o_hs_mode,
  output logic o_in_reset,
  output logic o_dev_pkt
);
  ulst_host_st_t st;
  logic [31:0] cnt;
  logic [31:0] seg_cnt;
  logic [31:0] wake_cnt;
  logic chirping;
  logic chirp_done;
  logic kj;
  logic dev_k;
  logic dev_k_q;
  logic eop_q;

  assign dev_k = link.dev_drive && (link.dev_line == LINE_K);

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      st <= H_DETACH;
      cnt <= 32'h0;
      seg_cnt <= 32'h0;
      chirping <= 1'b0;
      chirp_done <= 1'b0;
      kj <= 1'b0;
      dev_k_q <= 1'b0;
    end else begin
      dev_k_q <= dev_k;
      unique case (st)
        H_DETACH: begin
          cnt <= 32'h0;
          if (link.dev_attach) begin
            st <= H_DEBOUNCE;
          end
        end
        H_DEBOUNCE: begin
          cnt <= cnt + 32'h1;
          if (!link.dev_attach) begin
            st <= H_DETACH;
          end else if (cnt == 32'(P_DEBOUNCE_CYC - 1)) begin
            st <= H_RESET;
            cnt <= 32'h0;
            chirping <= 1'b0;
            chirp_done <= 1'b0;
          end
        end
        H_RESET: begin
          cnt <= cnt + 32'h1;
          if (dev_k_q && !dev_k && i_hs_capable && !chirp_done &&
              !chirping) begin
            chirping <= 1'b1;
            seg_cnt <= 32'h0;
            kj <= 1'b0;
          end else if (chirping) begin
            seg_cnt <= seg_cnt + 32'h1;
            if (seg_cnt == 32'(P_KJ_CYC - 1)) begin
              seg_cnt <= 32'h0;
              kj <= ~kj;
            end
            if (cnt >= 32'(P_RESET_CYC - P_FSC_LEAD_CYC - 1)) begin
              chirping <= 1'b0;
              chirp_done <= 1'b1;
            end
          end
          if (cnt == 32'(P_RESET_CYC - 1)) begin
            st <= H_IDLE;
            chirping <= 1'b0;
          end
        end
        H_IDLE: begin
          cnt <= 32'h0;
          if (!link.dev_attach) begin
            st <= H_DETACH;
          end else if (i_bus_reset) begin
            st <= H_RESET;
            chirping <= 1'b0;
            chirp_done <= 1'b0;
          end else if (i_resume) begin
            st <= H_RESUME;
          end
        end
        H_RESUME: begin
          cnt <= cnt + 32'h1;
          if (cnt == 32'(P_RESUME_CYC - 1)) begin
            st <= H_IDLE;
          end
        end
        default: begin
          st <= H_DETACH;
        end
      endcase
    end
  end

  assign link.host_drive = (st == H_RESET) || (st == H_RESUME);
  assign link.host_line = (st == H_RESUME) ? LINE_K :
                          chirping ? (kj ? LINE_J : LINE_K) : LINE_SE0;

  // one fixed-length pulse per request; a request while busy is dropped
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      wake_cnt <= 32'h0;
    end else if (wake_cnt != 32'h0) begin
      wake_cnt <= wake_cnt - 32'h1;
    end else if (i_wake) begin
      wake_cnt <= 32'(P_WAKE_CYC);
    end
  end
  assign link.resume_request_in = wake_cnt != 32'h0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      eop_q <= 1'b0;
      o_connected <= 1'b0;
      o_hs_mode <= 1'b0;
      o_in_reset <= 1'b0;
      o_dev_pkt <= 1'b0;
    end else begin
      eop_q <= (st == H_IDLE) && i_pkt_end;
      o_connected <= st == H_IDLE;
      o_hs_mode <= chirp_done;
      o_in_reset <= st == H_RESET;
      o_dev_pkt <= link.dev_pkt;
    end
  end
  assign link.host_eop = eop_q;
endmodule // ulst_host
`default_nettype wire

// ==== tb/ulst_props.sv ====
// checker: timing relations on the shared link wires
// assumes the shortened counts the bench gives both ends
`timescale 1ns/100ps
`default_nettype none
module ulst_props import ulst_pkg::*; #(
  parameter int P_CSR_CYC = 40,
  parameter int P_CHIRP_K_CYC = 300,
  parameter int P_DEBOUNCE_CYC = 20,
  parameter int P_RESET_CYC = 6000,
  parameter int P_FSC_LEAD_CYC = 400,
  parameter int P_WAKE_CYC = 100,
  parameter int P_RESUME_CYC = 50
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic dev_attach,
  input wire logic dev_drive,
  input wire logic [1:0] dev_line,
  input wire logic dev_pkt,
  input wire logic host_drive,
  input wire logic [1:0] host_line,
  input wire logic host_eop,
  input wire logic resume_request_in,
  input wire logic [1:0] line
);
  localparam int DB_HI = P_DEBOUNCE_CYC + 2;
  localparam int CS_HI = C_SCA + 10;
  localparam int LD_LO = P_FSC_LEAD_CYC - 3;
  localparam int LD_HI = P_FSC_LEAD_CYC + 3;
  logic chirp;
  int gap, ck_len, wk_len, drv_len, hk_gap, hseg;
  // host wins the line, so the device chirp shows on its own wires only
  assign chirp = dev_drive && host_drive && dev_line == LINE_K;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || host_eop || dev_pkt) gap <= 0;
    else if (gap < 9999) gap <= gap + 1;
  end
  always_ff @(posedge i_sys_clk) ck_len <= chirp ? ck_len + 1 : 0;
  always_ff @(posedge i_sys_clk) wk_len <= resume_request_in ? wk_len + 1 : 0;
  always_ff @(posedge i_sys_clk) drv_len <= host_drive ? drv_len + 1 : 0;
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) hk_gap <= 9999;
    else if (host_drive && host_line != LINE_SE0) hk_gap <= 0;
    else if (hk_gap < 9999) hk_gap <= hk_gap + 1;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) hseg <= 0;
    else hseg <= (host_line == $past(host_line)) ? hseg + 1 : 0;
  end
  a_pkt_gap: assert property ($rose(dev_pkt) |-> gap >= C_IPD)
    else $error("device packet too soon");
  a_debounce_wait: assert property ($rose(dev_attach) |->
    ##[P_DEBOUNCE_CYC:DB_HI] $rose(host_drive)) else $error("debounce off");
  a_chirp_width: assert property ($fell(chirp) |->
    ck_len inside {[P_CHIRP_K_CYC:P_CHIRP_K_CYC + 1]})
    else $error("chirp width wrong");
  a_reset_chirp: assert property (
    $rose(host_drive) && host_line == LINE_SE0 |->
    ##[P_CSR_CYC:CS_HI] $rose(chirp)) else $error("chirp start wrong");
  a_wake_width: assert property ($fell(resume_request_in) |->
    wk_len == P_WAKE_CYC) else $error("wake width wrong");
  a_kj_lead: assert property ($fell(host_drive) &&
    $past(host_line) == LINE_SE0 && hk_gap < 2 * P_FSC_LEAD_CYC |->
    hk_gap >= LD_LO && hk_gap <= LD_HI) else $error("chirp tail wrong");
  // a reset cuts a drive short, so that fall is not measured
  a_drive_len: assert property ($fell(host_drive) && $past(i_nrst) |->
    drv_len inside
    {[P_RESET_CYC - 1:P_RESET_CYC + 1], [P_RESUME_CYC - 1:P_RESUME_CYC + 1]})
    else $error("host drive length wrong");
  a_host_seg: assert property (host_drive && $past(host_drive) &&
    host_line != $past(host_line) && host_line != LINE_SE0 &&
    $past(host_line) != LINE_SE0 |-> hseg >= C_CSI)
    else $error("host chirp segment short");
  a_kj_start: assert property (host_drive && $past(host_drive) &&
    host_line == LINE_K && $past(host_line) == LINE_SE0 |->
    $past(dev_drive, 2) && !$past(dev_drive))
    else $error("host chirp start wrong");
  a_idle_line: assert property (
    dev_attach && !dev_drive && !host_drive |-> line == LINE_J)
    else $error("idle line not J");
  c_chirp: cover property ($fell(chirp));
  c_wake: cover property ($fell(resume_request_in));
  c_pkt: cover property ($rose(dev_pkt));
endmodule // ulst_props
`default_nettype wire

// ==== tb/ulst_tb.sv ====
// bench: device and host ends joined by the link carrier, checker beside
// assumes shortened counts; expectations derive from them, packet gaps from C_IPD
`timescale 1ns/100ps
`default_nettype none
module ulst_tb import ulst_pkg::*; ;
  localparam int CSR = 40;
  localparam int RST = 6000;
  localparam int CHK = 300;
  localparam int HSW = 3000;
  localparam int DB = 20;
  localparam int LEAD = 400;
  localparam int KJ = 300;
  localparam int WK = 100;
  localparam int RSM = 50;
  typedef struct packed {logic hs; logic flag; logic [7:0] idle;} ulst_row_t;
  // idle rows let the device suspend first, so reset comes from suspend
  ulst_row_t rows [3] = '{'{1'b1, 1'b1, 8'h00}, '{1'b0, 1'b0, 8'h3C},
    '{1'b1, 1'b1, 8'h3C}};
  logic i_sys_clk, i_nrst, pg, tx_req, tx_done, hs_cap, bus_rst, resume, wake;
  logic pkt_end, tx_rdy, tx_act, speed, rst_evt, susp, resm, conn, hs_mode;
  logic in_rst, dpkt;
  int n_mismatch, tests_run, n;
  ulst_link_if link ();
  ulst_dev #(.P_CSR_CYC(CSR), .P_CHIRP_K_CYC(CHK), .P_HS_WIN_CYC(HSW))
    u_ulst_dev (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link.dev),
    .i_power_good(pg), .i_tx_req(tx_req), .i_tx_done(tx_done),
    .o_tx_ready(tx_rdy), .o_tx_active(tx_act), .o_link_speed_flag(speed),
    .o_bus_reset_event(rst_evt), .o_suspend_indicator_out(susp),
    .o_resume_indicator_out(resm));
  ulst_host #(.P_DEBOUNCE_CYC(DB), .P_RESET_CYC(RST), .P_FSC_LEAD_CYC(LEAD),
    .P_KJ_CYC(KJ), .P_WAKE_CYC(WK), .P_RESUME_CYC(RSM))
    u_ulst_host (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link.host),
    .i_hs_capable(hs_cap), .i_bus_reset(bus_rst), .i_resume(resume),
    .i_wake(wake), .i_pkt_end(pkt_end), .o_connected(conn),
    .o_hs_mode(hs_mode), .o_in_reset(in_rst), .o_dev_pkt(dpkt));
  ulst_props #(.P_CSR_CYC(CSR), .P_CHIRP_K_CYC(CHK), .P_DEBOUNCE_CYC(DB),
    .P_RESET_CYC(RST), .P_FSC_LEAD_CYC(LEAD), .P_WAKE_CYC(WK),
    .P_RESUME_CYC(RSM)) u_ulst_props (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .dev_attach(link.dev_attach), .dev_drive(link.dev_drive),
    .dev_line(link.dev_line), .dev_pkt(link.dev_pkt),
    .host_drive(link.host_drive), .host_line(link.host_line),
    .host_eop(link.host_eop), .resume_request_in(link.resume_request_in),
    .line(link.line));
  task automatic tick();
    @(negedge i_sys_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk_cyc(input string nm, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return link.dev_attach;
      1: return rst_evt;
      2: return link.host_eop;
      3: return link.dev_pkt;
      4: return susp;
      default: return resm;
    endcase
  endfunction
  // bounded wait; n ends as the number of cycles waited
  task automatic wait_on(input string nm, input int k, input int lim);
    n = 0;
    while (pick(k) !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    chk_bit(nm, 1'b1, pick(k));
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #(10 * 60000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {i_nrst, pg, tx_req, tx_done, hs_cap, bus_rst, resume, wake} = 8'h00;
    pkt_end = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (5) tick();
    i_nrst = 1'b1;
    pg = 1'b1;
    wait_on("attach", 0, 4);
    wait_on("first reset", 1, RST + 400);
    foreach (rows[i]) begin
      hs_cap = rows[i].hs;
      repeat (rows[i].idle) tick();
      pulse(bus_rst);
      tick();
      chk_bit("host in reset", 1'b1, in_rst);
      wait_on("reset event", 1, RST + 400);
      chk_bit("connected", 1'b1, conn);
      chk_bit("speed flag", rows[i].flag, speed);
      chk_bit("host speed", rows[i].flag, hs_mode);
      $display("test row %0d done", i);
    end
    pulse(pkt_end);
    wait_on("host eop", 2, 4);
    tx_req = 1'b1;
    wait_on("reply start", 3, 60);
    chk_cyc("reply gap", C_IPD + 1, n);
    chk_bit("reply window", 1'b1, n <= C_RSP_MAX);
    chk_bit("tx active", 1'b1, tx_act);
    chk_bit("ready while busy", 1'b0, tx_rdy);
    pulse(tx_done);
    wait_on("next start", 3, 60);
    chk_cyc("back to back gap", C_IPD, n);
    tick();
    chk_bit("host sees packet", 1'b1, dpkt);
    tx_req = 1'b0;
    pulse(tx_done);
    $display("test packet gaps done");
    for (int k = 0; k < 2; k++) begin
      wait_on("suspend", 4, CSR + 20);
      if (k == 0) pulse(wake);
      else pulse(resume);
      wait_on("resume pulse", 5, 300);
      chk_bit("suspend cleared", 1'b0, susp);
      chk_bit("speed kept", 1'b1, speed);
      $display("test wake %0d done", k);
    end
    i_nrst = 1'b0;
    tick();
    chk_bit("attach in reset", 1'b0, link.dev_attach);
    chk_bit("speed in reset", 1'b0, speed);
    chk_bit("suspend in reset", 1'b0, susp);
    chk_bit("connected in reset", 1'b0, conn);
    i_nrst = 1'b1;
    wait_on("attach again", 0, 4);
    pg = 1'b0;
    tick();
    chk_bit("detach on power loss", 1'b0, link.dev_attach);
    $display("test reset done");
    give_verdict();
  end
endmodule // ulst_tb
`default_nettype wire
